//--- shared/gain_offset_pkg.sv
// Register map, field layout and reset values for the converter 5-8 configuration bank
package gain_offset_pkg;
    // Offsets are word indices; the bus byte address is four times the index
    localparam logic [7:0]  IDX_ODD_GAIN_OFFSET  = 8'h1f;
    localparam logic [7:0]  IDX_EVEN_GAIN_OFFSET = 8'h20;
    localparam logic [7:0]  IDX_LANE_HPF_CFG     = 8'h21;
    localparam logic [7:0]  IDX_CTRL             = 8'h22;
    localparam logic [15:0] RESET_VALUE          = 16'h0000;
    // Gain/offset register fields
    localparam int GAIN_MSB   = 15;
    localparam int GAIN_LSB   = 11;
    localparam int OFFS_MSB   = 9;
    localparam int OFFS_LSB   = 0;
    // Lane pattern / high-pass register fields
    localparam int PRBS_MSB   = 15;
    localparam int PRBS_LSB   = 12;
    localparam int PAT5_MSB   = 11;
    localparam int PAT5_LSB   = 9;
    localparam int PAT6_MSB   = 8;
    localparam int PAT6_LSB   = 6;
    localparam int HPFK_MSB   = 4;
    localparam int HPFK_LSB   = 1;
    localparam int HPFEN_BIT  = 0;
    // Control register fields
    localparam int GAIN_EN_BIT = 0;
    localparam int OFFS_EN_BIT = 1;
    localparam int PAT_IND_BIT = 2;
    // Legal corner range
    localparam logic [3:0]  HPF_K_MIN = 4'h2;
    localparam logic [3:0]  HPF_K_MAX = 4'ha;
    // Mask of writable control bits (spare control bits never store)
    localparam logic [15:0] CTRL_MASK = 16'h0007;
    // Unmapped read answer
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage

//--- design/gain_offset_regs.sv
// Avalon-MM register bank for converter 8 gain/offset, lane patterns and high-pass setup
// Functional notes
// [RULE1] Odd-sample gain is the 5-bit field N times 0.2 dB while gain enabled.
// [RULE2] Even-sample gain is its own 5-bit field N times 0.2 dB while enabled.
// [RULE3] Odd samples have the 10-bit odd offset subtracted while offset enabled.
// [RULE4] Even samples have the 10-bit even offset subtracted while offset enabled.
// [RULE5] Offsets are signed two's complement, one LSB equals one 14-bit sample LSB.
// [RULE6] Per-lane mode: bits 15..12 turn on PRBS for lanes 5..8.
// [RULE7] Per-lane mode: bits 11..9 pick lane 5 pattern, bits 8..6 lane 6.
// [RULE8] High-pass corner k drives the filter; software writes only k 2 to 10.
// [RULE9] Bit 0 enables the high-pass filter; zero, the default, bypasses it.
// [RULE10] With global gain or offset enable clear, that correction is not applied.
//
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/1ps
module gain_offset_regs
    import gain_offset_pkg::*;
(
    // Clock, reset and the Avalon-MM slave
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    input  wire logic [9:0]  address_i,
    input  wire logic        read_i,
    input  wire logic        write_i,
    input  wire logic [31:0] writedata_i,
    input  wire logic [3:0]  byteenable_i,
    output logic      [31:0] readdata_o,
    output logic             waitrequest_o,
    // Converter 8 correction settings, already gated by the global enables
    output logic      [4:0]  odd_sample_gain_o,
    output logic      [4:0]  even_sample_gain_o,
    output logic      [13:0] odd_sample_offset_o,
    output logic      [13:0] even_sample_offset_o,
    // Per-lane test pattern selection
    output logic      [3:0]  lane_prbs_enable_o,
    output logic      [2:0]  lane5_pattern_code_o,
    output logic      [2:0]  lane6_pattern_code_o,
    // Shared high-pass filter setup and the range warning
    output logic      [3:0]  highpass_corner_k_o,
    output logic             highpass_enable_o,
    output logic             corner_illegal_o
);

    logic [15:0] odd_reg;
    logic [15:0] even_reg;
    logic [15:0] lane_reg;
    logic [15:0] ctrl_reg;
    logic        ack;

    // Word index decode; byte address is four times the index
    wire  [7:0]  word_idx   = address_i[9:2];
    wire         req        = read_i | write_i;
    wire         sel_odd    = (word_idx == IDX_ODD_GAIN_OFFSET);
    wire         sel_even   = (word_idx == IDX_EVEN_GAIN_OFFSET);
    wire         sel_lane   = (word_idx == IDX_LANE_HPF_CFG);
    wire         sel_ctrl   = (word_idx == IDX_CTRL);
    wire         wr_go      = write_i & ack;
    wire  [15:0] be_mask    = {{8{byteenable_i[1]}}, {8{byteenable_i[0]}}};

    // Merge write data into a register under the byte lanes
    function automatic logic [15:0] merge(input logic [15:0] old_v, input logic [15:0] new_v,
                                          input logic [15:0] mask);
        merge = (old_v & ~mask) | (new_v & mask);
    endfunction

    // Sign-extend a 10-bit offset to 14-bit sample weight
    function automatic logic [13:0] sext_offs(input logic [15:0] r);
        sext_offs = {{4{r[OFFS_MSB]}}, r[OFFS_MSB:OFFS_LSB]};
    endfunction

    wire  [15:0] rd_word = sel_odd  ? odd_reg  :
                           sel_even ? even_reg :
                           sel_lane ? lane_reg :
                           sel_ctrl ? ctrl_reg : 16'h0000;
    wire         rd_hit  = sel_odd | sel_even | sel_lane | sel_ctrl;

    // Every access takes one wait cycle so readdata is registered when waitrequest drops.
    // The fixed latency costs a cycle per access but keeps the read path a plain flop.
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
            ack <= 1'b0;
        else
            ack <= req & ~ack;
    end

    // Waitrequest is its own flop, always the inverse of ack; high while idle
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
            waitrequest_o <= 1'b1;
        else
            waitrequest_o <= ~(req & ~ack);
    end

    // Correction words; reads have no side effect. Must-write-zero bits are stored
    // as written so software reads back exactly what it wrote.
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            odd_reg  <= RESET_VALUE;
            even_reg <= RESET_VALUE;
        end
        else if (wr_go)
        begin
            if (sel_odd)
                odd_reg  <= merge(odd_reg, writedata_i[15:0], be_mask);
            if (sel_even)
                even_reg <= merge(even_reg, writedata_i[15:0], be_mask);
        end
    end

    // Lane/filter word and the global enables; spare control bits cannot be set
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            lane_reg <= RESET_VALUE;
            ctrl_reg <= RESET_VALUE;
        end
        else if (wr_go)
        begin
            if (sel_lane)
                lane_reg <= merge(lane_reg, writedata_i[15:0], be_mask);
            if (sel_ctrl)
                ctrl_reg <= merge(ctrl_reg, writedata_i[15:0], be_mask & CTRL_MASK);
        end
    end

    // Read data captured in the wait cycle; unmapped words read zero
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
            readdata_o <= UNMAPPED_DATA;
        else if (read_i & ~ack)
            readdata_o <= rd_hit ? {16'h0000, rd_word} : UNMAPPED_DATA;
    end

    // Enable gating for the datapath; outputs registered from the stored fields
    wire         gain_on  = ctrl_reg[GAIN_EN_BIT];
    wire         offs_on  = ctrl_reg[OFFS_EN_BIT];
    wire         pat_on   = ctrl_reg[PAT_IND_BIT];
    wire  [3:0]  k_now    = lane_reg[HPFK_MSB:HPFK_LSB];
    wire         hpf_on   = lane_reg[HPFEN_BIT];
    // Gain code N means N x 0.2 dB; zero code is unity so disabled gain drives zero
    wire  [4:0]  next_odd_gain   = gain_on ? odd_reg[GAIN_MSB:GAIN_LSB]  : 5'h00; // [RULE1] [RULE10]
    wire  [4:0]  next_even_gain  = gain_on ? even_reg[GAIN_MSB:GAIN_LSB] : 5'h00; // [RULE2] [RULE10]
    // Offset to subtract, already widened to sample weight
    wire  [13:0] next_odd_offs   = offs_on ? sext_offs(odd_reg)  : 14'h0000; // [RULE3] [RULE5] [RULE10]
    wire  [13:0] next_even_offs  = offs_on ? sext_offs(even_reg) : 14'h0000; // [RULE4] [RULE5] [RULE10]
    // Bit 15 maps to lane 5 so the vector is reversed into lane order
    wire  [3:0]  next_prbs;
    for (genvar i = 0; i < 4; i++)
    begin : g_prbs_lane
        assign next_prbs[i] = pat_on & lane_reg[PRBS_MSB - i]; // [RULE6]
    end
    wire  [2:0]  next_pat5 = pat_on ? lane_reg[PAT5_MSB:PAT5_LSB] : 3'h0; // [RULE7]
    wire  [2:0]  next_pat6 = pat_on ? lane_reg[PAT6_MSB:PAT6_LSB] : 3'h0; // [RULE7]
    // Corner only matters with the filter on; bypass forces the corner output to zero
    wire  [3:0]  next_k    = hpf_on ? k_now : 4'h0; // [RULE8]
    // Out-of-range k is flagged, not corrected, since software owns the range
    wire         next_bad  = hpf_on & ((k_now < HPF_K_MIN) | (k_now > HPF_K_MAX)); // [RULE8]

    // Correction settings, registered so the datapath never sees a half-written word
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            odd_sample_gain_o    <= 5'h00;
            even_sample_gain_o   <= 5'h00;
            odd_sample_offset_o  <= 14'h0000;
            even_sample_offset_o <= 14'h0000;
        end
        else
        begin
            odd_sample_gain_o    <= next_odd_gain;
            even_sample_gain_o   <= next_even_gain;
            odd_sample_offset_o  <= next_odd_offs;
            even_sample_offset_o <= next_even_offs;
        end
    end

    // Lane pattern selections
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            lane_prbs_enable_o   <= 4'h0;
            lane5_pattern_code_o <= 3'h0;
            lane6_pattern_code_o <= 3'h0;
        end
        else
        begin
            lane_prbs_enable_o   <= next_prbs;
            lane5_pattern_code_o <= next_pat5;
            lane6_pattern_code_o <= next_pat6;
        end
    end

    // High-pass setup and the out-of-range warning
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            highpass_corner_k_o  <= 4'h0;
            highpass_enable_o    <= 1'b0;
            corner_illegal_o     <= 1'b0;
        end
        else
        begin
            highpass_corner_k_o  <= next_k;
            highpass_enable_o    <= hpf_on; // [RULE9]
            corner_illegal_o     <= next_bad;
        end
    end

    // Checks; the bus is synchronous, so one clock and one reset serve every property
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    // Gain outputs follow the stored codes one cycle late, or zero when gain is off.
    // Zero is unity gain, so a disabled block and a zero code look the same downstream.
    a_odd_gain_follow: assert property ( // [RULE1]
        1 |=> odd_sample_gain_o == ($past(gain_on) ? $past(odd_reg[GAIN_MSB:GAIN_LSB]) : 5'h00))
        else $error("odd gain output mismatch");
    a_even_gain_follow: assert property ( // [RULE2]
        1 |=> even_sample_gain_o == ($past(gain_on) ? $past(even_reg[GAIN_MSB:GAIN_LSB]) : 5'h00))
        else $error("even gain output mismatch");
    a_gain_off_zero: assert property ( // [RULE10]
        !gain_on |=> odd_sample_gain_o == 5'h00 && even_sample_gain_o == 5'h00)
        else $error("gain applied while disabled");

    // Offsets are widened with the field's own sign bit, never zero filled
    a_odd_offset_sext: assert property ( // [RULE3]
        offs_on |=> odd_sample_offset_o ==
                    {{4{$past(odd_reg[OFFS_MSB])}}, $past(odd_reg[OFFS_MSB:OFFS_LSB])})
        else $error("odd offset output mismatch");
    a_even_offset_sext: assert property ( // [RULE4]
        offs_on |=> even_sample_offset_o ==
                    {{4{$past(even_reg[OFFS_MSB])}}, $past(even_reg[OFFS_MSB:OFFS_LSB])})
        else $error("even offset output mismatch");
    a_offset_sign_range: assert property ( // [RULE5]
        ##1 odd_sample_offset_o[13:OFFS_MSB] == {5{odd_sample_offset_o[OFFS_MSB]}})
        else $error("offset sign extension broken");
    a_even_sign_range: assert property ( // [RULE5]
        even_sample_offset_o[13:OFFS_MSB] == {5{even_sample_offset_o[OFFS_MSB]}})
        else $error("even offset sign extension broken");
    a_offset_off_zero: assert property ( // [RULE10]
        !offs_on |=> odd_sample_offset_o == 14'h0000 && even_sample_offset_o == 14'h0000)
        else $error("offset applied while disabled");

    // Lane selections only leave the block in per-lane mode
    a_prbs_lane5_map: assert property ( // [RULE6]
        pat_on && lane_reg[PRBS_MSB] |=> lane_prbs_enable_o[0])
        else $error("lane 5 prbs not driven");
    a_prbs_off_zero: assert property ( // [RULE6]
        !pat_on |=> lane_prbs_enable_o == 4'h0)
        else $error("prbs driven outside per-lane mode");
    a_pattern_lane_map: assert property ( // [RULE7]
        pat_on |=> lane5_pattern_code_o == $past(lane_reg[PAT5_MSB:PAT5_LSB])
                   && lane6_pattern_code_o == $past(lane_reg[PAT6_MSB:PAT6_LSB]))
        else $error("lane pattern mismatch");
    a_pattern_off_zero: assert property ( // [RULE7]
        !pat_on |=> lane5_pattern_code_o == 3'h0 && lane6_pattern_code_o == 3'h0)
        else $error("pattern driven outside per-lane mode");

    // Corner passes through untouched; a value outside the legal range is only flagged.
    // Clamping was rejected because it would hide a software fault from the filter.
    a_corner_k_range: assert property ( // [RULE8]
        hpf_on && k_now >= HPF_K_MIN && k_now <= HPF_K_MAX
        |=> !corner_illegal_o && highpass_corner_k_o == $past(k_now))
        else $error("corner handling mismatch");
    a_corner_bad_flag: assert property ( // [RULE8]
        hpf_on && (k_now < HPF_K_MIN || k_now > HPF_K_MAX) |=> corner_illegal_o)
        else $error("illegal corner not flagged");
    a_hpf_enable_bit: assert property ( // [RULE9]
        $rose(lane_reg[HPFEN_BIT]) |-> ##1 highpass_enable_o)
        else $error("high-pass enable not following bit 0");
    a_hpf_enable_follow: assert property ( // [RULE9]
        1 |=> highpass_enable_o == $past(lane_reg[HPFEN_BIT]))
        else $error("high-pass enable level mismatch");
    a_hpf_off_corner: assert property ( // [RULE9]
        !hpf_on |=> highpass_corner_k_o == 4'h0 && !corner_illegal_o)
        else $error("corner active while filter bypassed");

    // Bus timing: exactly one wait cycle, idle high, stores only at the answering edge
    a_bus_one_wait: assert property (
        req && waitrequest_o |=> !waitrequest_o)
        else $error("bus answer late");
    a_bus_idle_wait: assert property (
        !req |=> waitrequest_o)
        else $error("waitrequest low without a request");
    a_store_on_ack: assert property (
        !wr_go |=> $stable(odd_reg) && $stable(even_reg) && $stable(lane_reg) && $stable(ctrl_reg))
        else $error("register changed outside a write");
    a_ctrl_spare_zero: assert property (
        (ctrl_reg & ~CTRL_MASK) == 16'h0000)
        else $error("spare control bit set");
    a_readdata_upper_zero: assert property (
        readdata_o[31:16] == 16'h0000)
        else $error("read data upper half not zero");

    // Main scenarios
    c_write_odd: cover property (wr_go && sel_odd);
    c_read_lane: cover property (read_i && ack && sel_lane);
    c_hpf_on: cover property ($rose(highpass_enable_o));
    c_bad_corner: cover property ($rose(corner_illegal_o));
    c_pattern_on: cover property ($rose(pat_on));

endmodule // gain_offset_regs

//--- testbench/testbench.sv
// Self-checking bench for the converter 5-8 gain, offset, lane pattern and high-pass register bank
`timescale 1ns/1ps
module testbench;
    import gain_offset_pkg::*;
    logic        ref_clk_i    = 1'b0;
    logic        rst_i        = 1'b1;
    logic [9:0]  address_i    = 10'h000;
    logic        read_i       = 1'b0;
    logic        write_i      = 1'b0;
    logic [31:0] writedata_i  = 32'h0;
    logic [3:0]  byteenable_i = 4'hf;
    logic [31:0] readdata_o;
    logic        waitrequest_o, highpass_enable_o, corner_illegal_o;
    logic [4:0]  odd_sample_gain_o, even_sample_gain_o;
    logic [13:0] odd_sample_offset_o, even_sample_offset_o;
    logic [3:0]  lane_prbs_enable_o, highpass_corner_k_o;
    logic [2:0]  lane5_pattern_code_o, lane6_pattern_code_o;
    logic [31:0] seed = 32'h1056;
    int          fails, check_count, cycles;

    gain_offset_regs u_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .address_i(address_i), .read_i(read_i),
        .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(byteenable_i), .readdata_o(readdata_o),
        .waitrequest_o(waitrequest_o), .odd_sample_gain_o(odd_sample_gain_o), .even_sample_gain_o(even_sample_gain_o),
        .odd_sample_offset_o(odd_sample_offset_o), .even_sample_offset_o(even_sample_offset_o),
        .lane_prbs_enable_o(lane_prbs_enable_o), .lane5_pattern_code_o(lane5_pattern_code_o),
        .lane6_pattern_code_o(lane6_pattern_code_o), .highpass_corner_k_o(highpass_corner_k_o),
        .highpass_enable_o(highpass_enable_o), .corner_illegal_o(corner_illegal_o));

    // 10 MHz clock
    always #50 ref_clk_i = ~ref_clk_i;

    // Hang guard; a full run needs about 740 cycles
    always @(posedge ref_clk_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fails++;
            close_out();
        end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Sign extension of a 10-bit offset field to the 14-bit sample width
    function automatic logic [13:0] sx10(input logic [9:0] v);
        return {{4{v[9]}}, v};
    endfunction

    // Legal high-pass word: the corner k is folded into 2 to 10, as software must keep it
    function automatic logic [15:0] legal_lane(input logic [15:0] r);
        return {r[15:5], 4'h2 + 4'(r[4:1] % 4'h9), r[0]};
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One bus cycle; the leading edge keeps two requests from being driven in one time step
    task automatic bus(input logic wr, input logic [9:0] addr, input logic [31:0] wd, input logic [3:0] be,
                       output logic [31:0] rd);
        @(posedge ref_clk_i);
        read_i       <= !wr;
        write_i      <= wr;
        address_i    <= addr;
        writedata_i  <= wd;
        byteenable_i <= be;
        do @(posedge ref_clk_i); while (waitrequest_o !== 1'b0);
        rd = readdata_o;
        read_i       <= 1'b0;
        write_i      <= 1'b0;
    endtask

    // Program all four words, read them back, then check every derived output
    task automatic cfg(input logic [2:0] c, input logic [15:0] o, input logic [15:0] e, input logic [15:0] l);
        logic [15:0] v[4];
        logic [31:0] rd;
        v = '{o, e, l, {13'h1fff, c}};
        for (int i = 0; i < 4; i++)
            bus(1'b1, 10'h07c + 10'(4 * i), {16'hffff, v[i]}, 4'hf, rd);
        v[3] = {13'h0, c};
        for (int i = 0; i < 4; i++)
        begin
            bus(1'b0, 10'h07c + 10'(4 * i), 32'h0, 4'hf, rd);
            check("readback", rd, {16'h0, v[i]});
        end
        check("odd_gain", odd_sample_gain_o, c[0] ? o[15:11] : 5'h0);
        check("even_gain", even_sample_gain_o, c[0] ? e[15:11] : 5'h0);
        check("odd_offset", odd_sample_offset_o, c[1] ? sx10(o[9:0]) : 14'h0);
        check("even_offset", even_sample_offset_o, c[1] ? sx10(e[9:0]) : 14'h0);
        check("prbs", lane_prbs_enable_o, c[2] ? {l[12], l[13], l[14], l[15]} : 4'h0);
        check("pat5", lane5_pattern_code_o, c[2] ? l[11:9] : 3'h0);
        check("pat6", lane6_pattern_code_o, c[2] ? l[8:6] : 3'h0);
        check("corner", highpass_corner_k_o, l[0] ? l[4:1] : 4'h0);
        check("illegal", corner_illegal_o, l[0] && (l[4:1] < 4'h2 || l[4:1] > 4'ha));
        check("hpf_en", highpass_enable_o, l[0]);
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Main sequence: reset state, corner cases, random traffic, unmapped and partial writes
    initial
    begin
        logic [31:0] rd;
        repeat (10) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            bus(1'b0, 10'h07c + 10'(4 * i), 32'h0, 4'hf, rd);
            check("reset_value", rd, 32'h0);
        end
        check("hpf_default", highpass_enable_o, 1'b0);
        cfg(3'h7, 16'hf9ff, 16'h0200, 16'hffc3);
        // Mid-run reset with every enable set; registers and outputs must fall back to zero, waitrequest to one
        rst_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        check("reset_wait", waitrequest_o, 1'b1);
        check("reset_gain", odd_sample_gain_o, 5'h00);
        check("reset_hpf", highpass_enable_o, 1'b0);
        bus(1'b0, 10'h084, 32'h0, 4'hf, rd);
        check("reset_lane", rd, 32'h0);
        cfg(3'h0, 16'hf9ff, 16'h0200, 16'h0015);
        cfg(3'h4, 16'h0000, 16'h0000, 16'h0005);
        cfg(3'h7, 16'h0001, 16'hffff, 16'h0017);
        cfg(3'h3, 16'h0400, 16'h03ff, 16'h0016);
        for (int n = 0; n < 24; n++)
        begin
            seed = lfsr(seed);
            cfg(seed[2:0], seed[31:16], seed[15:0] ^ seed[31:16], legal_lane(16'(lfsr(seed))));
        end
        bus(1'b1, 10'h08c, 32'h0000ffff, 4'hf, rd);
        bus(1'b0, 10'h08c, 32'h0, 4'hf, rd);
        check("unmapped", rd, 32'h0);
        bus(1'b1, 10'h07c, 32'h0000ffff, 4'hf, rd);
        bus(1'b1, 10'h07c, 32'h00000000, 4'h2, rd);
        bus(1'b0, 10'h07c, 32'h0, 4'hf, rd);
        check("byte_lane", rd, 32'h000000ff);
        close_out();
    end
endmodule // testbench
